//--- verilog/acc_map.vh
// acc_map.vh: register offsets, field positions and reset values of the comparator control
// assumes: included by the comparator control design over an Avalon-MM word bus
//
// Contract
// - bit 7 enables the comparator module
// - bit 6 selects pin or bandgap input
// - bit 5 flag sets on selected edge
// - writing one clears flag; zero ignored
// - bit 4 gates flag onto interrupt request
// - bit 3 reads output; zero when disabled
// - bit 2 drives comparator output onto pin
// - bits 1:0 pick falling, rising, either edge
// - logic keeps running during wait mode
// - shallow stop keeps comparing, flagging, waking
// - shallow stop keeps output pin driven
// - reset out of shallow stop restores reset
// - deep stop powers down; reset on wake; code resets only control and flag, interrupt status and mask keep theirs
// - debug halt leaves operation unchanged
// - output high when plus exceeds minus
`ifndef ACC_MAP_VH
`define ACC_MAP_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define ACC_OFS_CTRL    4'h0
`define ACC_OFS_IRQ_ST  4'h4
`define ACC_OFS_IRQ_MSK 4'h8

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define ACC_BIT_ENABLE  7
`define ACC_BIT_BGSEL   6
`define ACC_BIT_FLAG    5
`define ACC_BIT_IE      4
`define ACC_BIT_OUT     3
`define ACC_BIT_OPE     2
`define ACC_MODE_HI     1
`define ACC_MODE_LO     0
`define ACC_MODE_RISE   2'h1
`define ACC_MODE_BOTH   2'h3

// ------------------------------------------------------------
// status and mask register fields and reset values
// ------------------------------------------------------------
`define ACC_ST_EVENT    0
`define ACC_ST_RISE     1
`define ACC_ST_FALL     2
`define ACC_ST_W        3
`define ACC_CTRL_RST    8'h00
`define ACC_ST_RST      3'h0

`endif

//--- verilog/acc_ctrl.v
// acc_ctrl.v: digital control and status around an analog voltage comparator
// assumes: comparator output arrives asynchronously; bus is Avalon-MM, one clock
//
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`include "acc_map.vh"

module acc_ctrl (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        deep_stop,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        comparator_raw,
  output reg         comparator_enable,
  output reg         bandgap_input_select,
  output reg         comparator_output_pin,
  output reg         comparator_output_pin_oe,
  output reg         compare_irq,
  output reg         irq
);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  reg rst_s1_q;
  reg rst_s2_q;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  // deep stop holds control and flag at reset values; interrupt status and mask keep theirs
  wire rst_int_n = rst_s2_q;

  // ------------------------------------------------------------
  // comparator output synchroniser and edge detect
  // ------------------------------------------------------------
  reg cmp_s1_q;
  reg cmp_s2_q;
  reg cmp_prev_q;
  reg ctrl_en_q;
  reg ctrl_bg_q;
  reg ctrl_ie_q;
  reg ctrl_ope_q;
  reg [1:0] ctrl_mode_q;
  reg flag_q;
  // analog comparator is high when plus exceeds minus; sampled as-is
  always @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      cmp_s1_q   <= 1'b0;
      cmp_s2_q   <= 1'b0;
      cmp_prev_q <= 1'b0;
    end else begin
      cmp_s1_q   <= comparator_raw & ctrl_en_q;
      cmp_s2_q   <= cmp_s1_q;
      cmp_prev_q <= cmp_s2_q;
    end
  end

  // only deep_stop gates this logic, by clearing the enable: it runs in wait, stop3, debug
  wire rise = cmp_s2_q & ~cmp_prev_q & ctrl_en_q;
  wire fall = ~cmp_s2_q & cmp_prev_q & ctrl_en_q;
  reg  edge_hit;
  always @* begin
    case (ctrl_mode_q)
      `ACC_MODE_RISE: edge_hit = rise;
      `ACC_MODE_BOTH: edge_hit = rise | fall;
      default:        edge_hit = fall;
    endcase
  end

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  // every access answers on the second cycle: waitrequest drops for one edge
  reg  ack_q;
  wire acc_go  = (avs_read | avs_write) & avs_waitrequest & ~ack_q;
  wire wr_ok   = avs_write & ack_q;
  wire wr_ctrl = wr_ok & avs_byteenable[0] & (avs_address == `ACC_OFS_CTRL);
  wire wr_st   = wr_ok & avs_byteenable[0] & (avs_address == `ACC_OFS_IRQ_ST);
  wire wr_msk  = wr_ok & avs_byteenable[0] & (avs_address == `ACC_OFS_IRQ_MSK);
  wire [7:0] wd = avs_writedata[7:0];

  always @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      ack_q           <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_q           <= acc_go;
      avs_waitrequest <= ~acc_go;
    end
  end

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  always @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      ctrl_en_q   <= 1'b0;
      ctrl_bg_q   <= 1'b0;
      ctrl_ie_q   <= 1'b0;
      ctrl_ope_q  <= 1'b0;
      ctrl_mode_q <= 2'h0;
    end else if (deep_stop) begin
      ctrl_en_q   <= 1'b0;
      ctrl_bg_q   <= 1'b0;
      ctrl_ie_q   <= 1'b0;
      ctrl_ope_q  <= 1'b0;
      ctrl_mode_q <= 2'h0;
    end else if (wr_ctrl) begin
      // output status bit is read-only; flag handled separately
      ctrl_en_q   <= wd[`ACC_BIT_ENABLE];
      ctrl_bg_q   <= wd[`ACC_BIT_BGSEL];
      ctrl_ie_q   <= wd[`ACC_BIT_IE];
      ctrl_ope_q  <= wd[`ACC_BIT_OPE];
      ctrl_mode_q <= wd[`ACC_MODE_HI:`ACC_MODE_LO];
    end
  end

  // set wins over a same-cycle write-one clear
  always @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n)
      flag_q <= 1'b0;
    else if (deep_stop)
      flag_q <= 1'b0;
    else if (edge_hit)
      flag_q <= 1'b1;
    else if (wr_ctrl & wd[`ACC_BIT_FLAG])
      flag_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // interrupt status and mask
  // ------------------------------------------------------------
  reg [`ACC_ST_W-1:0] st_q;
  reg [`ACC_ST_W-1:0] msk_q;
  wire [`ACC_ST_W-1:0] st_set = {fall, rise, edge_hit};
  always @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      st_q  <= `ACC_ST_RST;
      msk_q <= `ACC_ST_RST;
    end else begin
      st_q <= st_set | (st_q & ~(wr_st ? wd[`ACC_ST_W-1:0] : `ACC_ST_RST));
      if (wr_msk)
        msk_q <= wd[`ACC_ST_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // outputs and read data
  // ------------------------------------------------------------
  wire [7:0] ctrl_rd = {ctrl_en_q, ctrl_bg_q, flag_q, ctrl_ie_q,
                        cmp_s2_q & ctrl_en_q, ctrl_ope_q, ctrl_mode_q};
  reg  [31:0] rd_mux;
  always @* begin
    case (avs_address)
      `ACC_OFS_CTRL:    rd_mux = {24'h000000, ctrl_rd};
      `ACC_OFS_IRQ_ST:  rd_mux = {29'h00000000, st_q};
      `ACC_OFS_IRQ_MSK: rd_mux = {29'h00000000, msk_q};
      default:          rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      avs_readdata             <= 32'h00000000;
      comparator_enable        <= 1'b0;
      bandgap_input_select     <= 1'b0;
      comparator_output_pin    <= 1'b0;
      comparator_output_pin_oe <= 1'b0;
      compare_irq              <= 1'b0;
      irq                      <= 1'b0;
    end else begin
      avs_readdata             <= (avs_read & acc_go) ? rd_mux : 32'h00000000;
      comparator_enable        <= ctrl_en_q;
      bandgap_input_select     <= ctrl_bg_q;
      comparator_output_pin    <= ctrl_ope_q & cmp_s2_q;
      comparator_output_pin_oe <= ctrl_ope_q;
      compare_irq              <= ctrl_ie_q & flag_q;
      irq                      <= |(st_q & msk_q);
    end
  end

endmodule // acc_ctrl

//--- sim/acc_analog_model.sv
// acc_analog_model.sv: behavioural analog comparator on the far side of acc_ctrl
// assumes: input levels in millivolts, set by the bench
`timescale 1ns/1ps
module acc_analog_model #(parameter int BG_MV = 1200) (
  input  wire        en,
  input  wire        bg_sel,
  input  wire [11:0] pos_mv,
  input  wire [11:0] neg_mv,
  output wire        raw
);
  wire [11:0] plus_mv = bg_sel ? BG_MV[11:0] : pos_mv;
  // powered down it reads low; the block ignores it then
  assign raw = en && (plus_mv > neg_mv);
endmodule // acc_analog_model

//--- sim/acc_ctrl_properties.sv
// acc_ctrl_properties.sv: port-level checker for acc_ctrl
// assumes: bound to every acc_ctrl, one clock domain
`timescale 1ns/1ps
module acc_ctrl_props (
  input wire        core_clk,
  input wire        rst_n,
  input wire        deep_stop,
  input wire [3:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        comparator_raw,
  input wire        comparator_enable,
  input wire        bandgap_input_select,
  input wire        comparator_output_pin,
  input wire        comparator_output_pin_oe,
  input wire        compare_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire wr0 = avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0];
  wire rd0 = avs_read && !avs_waitrequest && avs_address == 4'h0;
  property p_en; wr0 |-> ##2 comparator_enable == $past(avs_writedata[7], 2); endproperty
  a_en: assert property (p_en) else $error("enable off ctrl");
  property p_bg; wr0 |-> ##2 bandgap_input_select == $past(avs_writedata[6], 2); endproperty
  a_bg: assert property (p_bg) else $error("select off ctrl");
  property p_clr; wr0 && avs_writedata[5] |-> ##2 !compare_irq; endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_ie; wr0 && !avs_writedata[4] |-> ##2 !compare_irq [*2]; endproperty
  a_ie: assert property (p_ie) else $error("request while disabled");
  property p_off; rd0 && !comparator_enable |-> avs_readdata[3] == 1'b0; endproperty
  a_off: assert property (p_off) else $error("output bit while off");
  property p_pin; !comparator_output_pin_oe |-> !comparator_output_pin; endproperty
  a_pin: assert property (p_pin) else $error("pin driven");
  property p_sync;
    (comparator_enable && comparator_output_pin_oe && $stable(comparator_raw)) [*5]
      |-> comparator_output_pin == comparator_raw;
  endproperty
  a_sync: assert property (p_sync) else $error("pin lags output");
  property p_deep; deep_stop [*3] |-> !comparator_enable && !comparator_output_pin_oe; endproperty
  a_deep: assert property (p_deep) else $error("deep stop kept state");
endmodule // acc_ctrl_props
bind acc_ctrl acc_ctrl_props u_acc_ctrl_props (.*);

//--- sim/acc_ctrl_tb.sv
// acc_ctrl_tb.sv: self-checking bench for acc_ctrl with an analog comparator model
// assumes: checker bound in its own file, 100 MHz clock
`timescale 1ns/1ps
`include "acc_map.vh"
module acc_ctrl_tb;
  logic        core_clk = 0;
  logic        rst_n = 0;
  logic        deep_stop = 0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [11:0] pos_mv = 12'h064;
  logic [11:0] neg_mv = 12'h1F4;
  logic [31:0] q;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, comparator_raw, comparator_enable, bandgap_input_select;
  wire         comparator_output_pin, comparator_output_pin_oe, compare_irq, irq;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cyc = 0;
  always #5 core_clk = ~core_clk;
  acc_ctrl u_acc_ctrl (.*);
  acc_analog_model u_acc_analog_model (.en(comparator_enable), .bg_sel(bandgap_input_select),
    .pos_mv(pos_mv), .neg_mv(neg_mv), .raw(comparator_raw));
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    avs_write <= w;
    avs_read <= ~w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] ex);
    bus(1'b0, a, 8'h00);
    chk("readdata", {24'h0, ex}, q);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      final_report;
    end
  end
  initial begin
    tick(12);
    rst_n <= 1'b1;
    tick(3);
    rd(`ACC_OFS_CTRL, 8'h00);
    bus(1'b1, 4'hC, 8'hFF);
    rd(4'hC, 8'h00);
    avs_byteenable <= 4'h0;
    bus(1'b1, `ACC_OFS_CTRL, 8'h80);
    avs_byteenable <= 4'hF;
    rd(`ACC_OFS_CTRL, 8'h00);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, `ACC_OFS_CTRL, 8'hBC | m[7:0]);
      tick(6);
      rd(`ACC_OFS_CTRL, 8'h94 | m[7:0]);
      pos_mv <= 12'h384;
      tick(6);
      rd(`ACC_OFS_CTRL, 8'h9C | m[7:0] | (m[0] ? 8'h20 : 8'h00));
      chk("compare_irq", m[0], compare_irq);
      chk("pin", 1, comparator_output_pin);
      bus(1'b1, `ACC_OFS_CTRL, 8'hB4 | m[7:0]);
      pos_mv <= 12'h064;
      tick(6);
      rd(`ACC_OFS_CTRL, 8'h94 | m[7:0] | (m != 1 ? 8'h20 : 8'h00));
    end
    rd(`ACC_OFS_IRQ_ST, 8'h07);
    chk("irq", 0, irq);
    bus(1'b1, `ACC_OFS_IRQ_MSK, 8'h01);
    tick(2);
    chk("irq", 1, irq);
    bus(1'b1, `ACC_OFS_IRQ_ST, 8'h01);
    tick(2);
    chk("irq", 0, irq);
    rd(`ACC_OFS_IRQ_ST, 8'h06);
    bus(1'b1, `ACC_OFS_CTRL, 8'h83);
    pos_mv <= 12'h384;
    tick(6);
    chk("compare_irq", 0, compare_irq);
    chk("pin_oe", 0, comparator_output_pin_oe);
    neg_mv <= 12'h3E8;
    bus(1'b1, `ACC_OFS_CTRL, 8'hE3); // bench takes the bandgap buffer as already enabled
    tick(6);
    rd(`ACC_OFS_CTRL, 8'hEB);
    bus(1'b1, `ACC_OFS_CTRL, 8'h00);
    rd(`ACC_OFS_CTRL, 8'h20);
    bus(1'b1, `ACC_OFS_CTRL, 8'h20);
    rd(`ACC_OFS_CTRL, 8'h00);
    bus(1'b1, `ACC_OFS_CTRL, 8'h84);
    deep_stop <= 1'b1;
    tick(3);
    deep_stop <= 1'b0;
    tick(1);
    rd(`ACC_OFS_CTRL, 8'h00);
    final_report;
  end
endmodule // acc_ctrl_tb
